// *** hdl/sbs_ctl.sv ***
// Controller end: makes the test clock and walks the device state machine.
// Assumes user requests are on clk; serial return data is asynchronous.
module sbs_ctl
   import sbs_pkg::*;
#(
   parameter int LEN_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   sbs_if.ctl link,
   input wire logic start,
   input wire logic is_ir,
   input wire logic go_reset,
   input wire logic [LEN_W-1:0] len,
   input wire logic [63:0] wdata,
   output logic busy,
   output logic done,
   output logic [63:0] rdata
);
   // ---------------------------------------------------------------
   // Test clock divider
   // ---------------------------------------------------------------
   logic [3:0] div_r;
   logic tck_r, tms_r, tdi_r;
   wire half = div_r == 4'(SBS_TCK_HALF - 1);
   wire rise_now = half & ~tck_r;
   wire fall_now = half & tck_r;

   always_ff @(posedge clk) begin
      if (rst || half) div_r <= '0;
      else div_r <= div_r + 4'h1;
   end

   always_ff @(posedge clk) begin
      if (rst) tck_r <= 1'b0;
      else if (half && busy) tck_r <= ~tck_r;
   end

   // Returning serial data synchronised
   logic [1:0] tdo_s_r;
   always_ff @(posedge clk) tdo_s_r <= {tdo_s_r[0], link.tdo};

   // ---------------------------------------------------------------
   // Sequencer: path of mode-select values
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {C_IDLE = 3'h0, C_HEAD = 3'h1, C_SHIFT = 3'h3,
      C_TAIL = 3'h2, C_RST = 3'h6} sbs_cst_e;
   sbs_cst_e cs_r;
   logic [2:0] step_r;
   logic [LEN_W-1:0] cnt_r;
   logic [63:0] sh_r;
   logic ir_r;
   wire [2:0] head_len = ir_r ? 3'h4 : 3'h3;

   // Head TMS: RTI->SelDR(1)->[SelIR(1)]->Cap(0)->Shift(0)
   wire head_tms = ir_r ? (step_r < 3'h2) : (step_r == 3'h0);

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_r <= C_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         tms_r <= 1'b1;
         tdi_r <= 1'b1;
         step_r <= '0;
         cnt_r <= '0;
         sh_r <= '0;
         ir_r <= 1'b0;
         rdata <= '0;
      end else begin
         done <= 1'b0;
         case (cs_r)
            C_IDLE: if (start) begin
               busy <= 1'b1;
               step_r <= '0;
               ir_r <= is_ir;
               cnt_r <= len;
               sh_r <= wdata;
               cs_r <= go_reset ? C_RST : C_HEAD;
               tms_r <= go_reset ? 1'b1 : 1'b0;
            end
            C_RST: if (fall_now) begin
               // Ones for five rises, then one zero rise into idle
               tms_r <= step_r < 3'(SBS_RESET_ONES - 1);
               step_r <= step_r + 3'h1;
               if (step_r == 3'(SBS_RESET_ONES)) begin
                  cs_r <= C_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            C_HEAD: if (fall_now) begin
               tms_r <= head_tms;
               step_r <= step_r + 3'h1;
               if (step_r == head_len) begin
                  cs_r <= C_SHIFT;
                  tms_r <= cnt_r == 1;
                  tdi_r <= sh_r[0];
               end
            end
            C_SHIFT: begin
               if (rise_now) sh_r <= {tdo_s_r[1], sh_r[63:1]};
               if (fall_now) begin
                  cnt_r <= cnt_r - 1'b1;
                  tdi_r <= sh_r[0];
                  tms_r <= cnt_r == 2;
                  if (cnt_r == 1) begin
                     cs_r <= C_TAIL;
                     step_r <= '0;
                     tms_r <= 1'b1;
                  end
               end
            end
            C_TAIL: if (fall_now) begin
               // Exit1 -> Update (1) -> Idle (0)
               step_r <= step_r + 3'h1;
               tms_r <= 1'b0;
               if (step_r == 3'h1) begin
                  cs_r <= C_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
                  rdata <= sh_r >> (7'd64 - 7'(len));
               end
            end
            default: cs_r <= C_IDLE;
         endcase
      end
   end

   assign link.tck = tck_r;
   assign link.tms = tms_r;
   assign link.tdi = tdi_r;
endmodule : sbs_ctl

// *** include/sbs_pkg.sv ***
// Constants shared by both ends of the reduced boundary-scan test port.
// Assumes one system clock; the test clock is a sampled signal, not a clock.
//
// Operation
// - All-zero instruction code is a valid instruction.
// - All-zero code acts as sample plus outputs floated.
// - Identification captures hardwired 32-bit code, shifts it.
// - Identification loaded at reset and Test-Logic-Reset.
// - Capture-and-float uses boundary register, floats outputs.
// - Sample captures input pins in Capture-DR.
// - Boundary register shifts out during Shift-DR.
// - No preload; Update-DR during sample changes nothing.
// - Bypass routes serial data through one bit.
// - Controller never loads reserved instruction codes.
// - Transitions follow mode select at rising test-clock edge.
// - Test clock runs no faster than 20 MHz.
// - Controller may ignore captured functional clock value.
// - Codes 000,001,010,100 decoded; 011,101 reserved.
// - Five high mode-select edges return to reset.
// - Capture-IR loads 01 into low two bits.
// - Sample on rising edge, output changes on falling.
package sbs_pkg;
   // ---------------------------------------------------------------
   // Widths and codes
   // ---------------------------------------------------------------
   localparam int SBS_IR_W = 3;
   localparam int SBS_ID_W = 32;
   localparam logic [2:0] SBS_OP_FLOAT_CAP = 3'h0;
   localparam logic [2:0] SBS_OP_IDENT = 3'h1;
   localparam logic [2:0] SBS_OP_CAP_FLOAT = 3'h2;
   localparam logic [2:0] SBS_OP_SAMPLE = 3'h4;
   localparam logic [2:0] SBS_OP_BYPASS = 3'h7;
   localparam logic [1:0] SBS_IR_CAPTURE = 2'h1;
   // Arbitrary identity value, ends in the presence bit
   localparam logic [31:0] SBS_ID_DEFAULT = 32'h0a5a_5001;
   localparam int SBS_RESET_ONES = 5;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SBS_CLK_MHZ = 25;
   localparam int SBS_TCK_MAX_MHZ = 20;
   // Shortest half period that keeps the test clock under its limit
   localparam int SBS_TCK_MIN_HALF =
      (SBS_CLK_MHZ + 2 * SBS_TCK_MAX_MHZ - 1) / (2 * SBS_TCK_MAX_MHZ);
   // Clocks from a test-clock fall until serial out is back through both synchronisers
   localparam int SBS_LOOP_CLKS = 6;
   // Half period of generated test clock: legal rate and room for the loop
   localparam int SBS_TCK_HALF =
      SBS_TCK_MIN_HALF > SBS_LOOP_CLKS ? SBS_TCK_MIN_HALF : SBS_LOOP_CLKS;

   // ---------------------------------------------------------------
   // Controller states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      SBS_TLR = 4'hf, SBS_RTI = 4'hc, SBS_SEL_DR = 4'h7, SBS_CAP_DR = 4'h6,
      SBS_SH_DR = 4'h2, SBS_EX1_DR = 4'h1, SBS_PA_DR = 4'h3, SBS_EX2_DR = 4'h0,
      SBS_UP_DR = 4'h5, SBS_SEL_IR = 4'h4, SBS_CAP_IR = 4'he, SBS_SH_IR = 4'ha,
      SBS_EX1_IR = 4'h9, SBS_PA_IR = 4'hb, SBS_EX2_IR = 4'h8, SBS_UP_IR = 4'hd
   } sbs_state_e;

   // Next controller state from mode select
   function automatic sbs_state_e sbs_next(input sbs_state_e s, input logic m);
      case (s)
         SBS_TLR: sbs_next = m ? SBS_TLR : SBS_RTI;
         SBS_RTI: sbs_next = m ? SBS_SEL_DR : SBS_RTI;
         SBS_SEL_DR: sbs_next = m ? SBS_SEL_IR : SBS_CAP_DR;
         SBS_CAP_DR: sbs_next = m ? SBS_EX1_DR : SBS_SH_DR;
         SBS_SH_DR: sbs_next = m ? SBS_EX1_DR : SBS_SH_DR;
         SBS_EX1_DR: sbs_next = m ? SBS_UP_DR : SBS_PA_DR;
         SBS_PA_DR: sbs_next = m ? SBS_EX2_DR : SBS_PA_DR;
         SBS_EX2_DR: sbs_next = m ? SBS_UP_DR : SBS_SH_DR;
         SBS_UP_DR: sbs_next = m ? SBS_SEL_DR : SBS_RTI;
         SBS_SEL_IR: sbs_next = m ? SBS_TLR : SBS_CAP_IR;
         SBS_CAP_IR: sbs_next = m ? SBS_EX1_IR : SBS_SH_IR;
         SBS_SH_IR: sbs_next = m ? SBS_EX1_IR : SBS_SH_IR;
         SBS_EX1_IR: sbs_next = m ? SBS_UP_IR : SBS_PA_IR;
         SBS_PA_IR: sbs_next = m ? SBS_EX2_IR : SBS_PA_IR;
         SBS_EX2_IR: sbs_next = m ? SBS_UP_IR : SBS_SH_IR;
         SBS_UP_IR: sbs_next = m ? SBS_SEL_DR : SBS_RTI;
         default: sbs_next = SBS_TLR;
      endcase
   endfunction : sbs_next
endpackage : sbs_pkg

// *** include/sbs_if.sv ***
// Serial test link between the board controller and the device port.
// Assumes both ends share clk; the test clock is a plain level here.
interface sbs_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;

   modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
   modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface : sbs_if

// *** hdl/sbs_dev.sv ***
// Device end: test port controller, instruction decode, data registers.
// Assumes test link pins arrive asynchronously and are synchronised here.
module sbs_dev
   import sbs_pkg::*;
#(
   parameter int BSR_W = 71,
   parameter logic [31:0] ID_CODE = SBS_ID_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   sbs_if.dev link,
   input wire logic [BSR_W-1:0] pins_in,
   output logic mem_float,
   output logic [SBS_IR_W-1:0] instr,
   output logic [3:0] tap_state
);
   // ---------------------------------------------------------------
   // Synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [1:0] tck_s_r, tms_s_r, tdi_s_r;
   logic tck_d_r;
   logic [BSR_W-1:0] pins_s1_r, pins_s2_r;

   // Two-stage capture of link and pin inputs
   always_ff @(posedge clk) begin
      tck_s_r <= {tck_s_r[0], link.tck};
      tms_s_r <= {tms_s_r[0], link.tms};
      tdi_s_r <= {tdi_s_r[0], link.tdi};
      tck_d_r <= tck_s_r[1];
      pins_s1_r <= pins_in;
      pins_s2_r <= pins_s1_r;
   end

   wire rise = tck_s_r[1] & ~tck_d_r;
   wire fall = ~tck_s_r[1] & tck_d_r;
   wire tms_v = tms_s_r[1];
   wire tdi_v = tdi_s_r[1];

   // ---------------------------------------------------------------
   // Controller and registers
   // ---------------------------------------------------------------
   sbs_state_e st_r;
   logic [SBS_IR_W-1:0] ir_sh_r, ir_r;
   logic [SBS_ID_W-1:0] id_r;
   logic [BSR_W-1:0] bsr_r;
   logic byp_r, tdo_r, oe_r;

   // Selection of the data register by the active instruction
   wire sel_id = ir_r == SBS_OP_IDENT;
   wire sel_bsr = ir_r == SBS_OP_FLOAT_CAP || ir_r == SBS_OP_CAP_FLOAT
      || ir_r == SBS_OP_SAMPLE;
   wire sel_byp = ~sel_id & ~sel_bsr;
   wire float_nxt = ir_r == SBS_OP_FLOAT_CAP
      || ir_r == SBS_OP_CAP_FLOAT;
   wire dr_lsb = sel_id ? id_r[0] : sel_bsr ? bsr_r[0] : byp_r;
   wire shifting = st_r == SBS_SH_DR || st_r == SBS_SH_IR;
   wire out_bit = st_r == SBS_SH_IR ? ir_sh_r[0] : dr_lsb;

   // State walk on rising test-clock edges
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= SBS_TLR;
      end else if (rise) begin
         st_r <= sbs_next(st_r, tms_v);
      end
   end

   // Instruction path
   always_ff @(posedge clk) begin
      if (rst || (rise && st_r == SBS_TLR)) begin
         ir_r <= SBS_OP_IDENT;
         ir_sh_r <= SBS_OP_IDENT;
      end else if (rise) begin
         case (st_r)
            SBS_CAP_IR: ir_sh_r <= {1'b0, SBS_IR_CAPTURE};
            SBS_SH_IR: ir_sh_r <= {tdi_v, ir_sh_r[SBS_IR_W-1:1]};
            SBS_UP_IR: ir_r <= ir_sh_r;
            default: ir_r <= ir_r;
         endcase
      end
   end

   // Data path; update-DR has no effect, so no preload
   always_ff @(posedge clk) begin
      if (rst) begin
         id_r <= '0;
         bsr_r <= '0;
         byp_r <= 1'b0;
      end else if (rise) begin
         case (st_r)
            SBS_CAP_DR: begin
               id_r <= ID_CODE;
               if (sel_bsr) bsr_r <= pins_s2_r;
               byp_r <= 1'b0;
            end
            SBS_SH_DR: begin
               if (sel_id) id_r <= {tdi_v, id_r[SBS_ID_W-1:1]};
               if (sel_bsr) bsr_r <= {tdi_v, bsr_r[BSR_W-1:1]};
               if (sel_byp) byp_r <= tdi_v;
            end
            default: bsr_r <= bsr_r;
         endcase
      end
   end

   // Serial output and enable change on falling edges only
   always_ff @(posedge clk) begin
      if (rst) begin
         tdo_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (fall) begin
         tdo_r <= out_bit;
         oe_r <= shifting;
      end
   end

   // Registered status outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_float <= 1'b0;
         instr <= SBS_OP_IDENT;
         tap_state <= SBS_TLR;
      end else begin
         mem_float <= float_nxt;
         instr <= ir_r;
         tap_state <= st_r;
      end
   end

   assign link.tdo = tdo_r;
   assign link.tdo_oe = oe_r;
endmodule : sbs_dev

// *** sim/sbs_chk.sv ***
// Checker on the serial link between controller and device ends.
// Assumes every link signal is sampled on clk.
module sbs_chk
   import sbs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Helper: mode-select ones on test-clock rises, saturating at five
   // ---------------------------------------------------------------
   logic [2:0] ones_r;
   logic [2:0] ones_nxt;
   assign ones_nxt = !tms ? 3'h0 : (ones_r == 3'h5 ? ones_r : ones_r + 3'h1);
   always_ff @(posedge clk) begin
      if (rst) begin
         ones_r <= 3'h0;
      end else if ($rose(tck)) begin
         ones_r <= ones_nxt;
      end
   end

   // Helper: clk cycles of the current test-clock high phase
   logic [3:0] high_r;
   always_ff @(posedge clk) begin
      if (rst || !tck) begin
         high_r <= 4'h0;
      end else begin
         high_r <= high_r + 4'h1;
      end
   end

   reset_idle_a: assert property ($fell(rst) |-> !tck && tms && !tdo_oe)
      else $error("link not idle after reset");
   tck_high_a: assert property ($fell(tck) |-> high_r == 4'(SBS_TCK_HALF))
      else $error("test clock high phase has wrong length");
   tms_setup_a: assert property ($rose(tck) |-> $stable(tms))
      else $error("mode select moved at test clock rise");
   tdi_setup_a: assert property ($rose(tck) |-> $stable(tdi))
      else $error("serial in moved at test clock rise");
   tdo_hold_a: assert property (tdo_oe && $changed(tdo) |=> !tdo_oe || $stable(tdo))
      else $error("serial out changed twice in one period");
   oe_min_a: assert property ($rose(tdo_oe) |=> tdo_oe)
      else $error("serial out enabled for one clk only");
   reset_float_a: assert property (ones_r == 3'h5 |-> !tdo_oe)
      else $error("serial out driven after five ones");
   oe_entry_a: assert property ($rose(tdo_oe) |-> ones_r < 3'h2)
      else $error("shift entered without low mode select");
endmodule : sbs_chk

// *** sim/sram_boundary_scan_instruction_unit_test.sv ***
// Bench for both link ends joined back to back.
// Assumes the controller end walks the device end; no model is added.
module sram_boundary_scan_instruction_unit_test
   import sbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BW = 8;
   // Arbitrary identity value with presence bit set
   localparam logic [31:0] DEV_ID = 32'h1357_9bdf;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic is_ir = 1'b0;
   logic go_reset = 1'b0;
   logic [7:0] len = 8'h1;
   logic [63:0] wdata = 64'h0;
   logic [BW-1:0] pins = 8'h0;
   logic busy, done, mem_float;
   logic [63:0] rdata;
   logic [2:0] instr;
   logic [3:0] tap_state;
   int miscompares = 0;
   int num_checks = 0;

   sbs_if sbs_if_i ();
   sbs_dev #(.BSR_W(BW), .ID_CODE(DEV_ID)) sbs_dev_i (.clk(clk), .rst(rst),
      .link(sbs_if_i.dev), .pins_in(pins), .mem_float(mem_float), .instr(instr),
      .tap_state(tap_state));
   sbs_ctl sbs_ctl_i (.clk(clk), .rst(rst), .link(sbs_if_i.ctl), .start(start),
      .is_ir(is_ir), .go_reset(go_reset), .len(len), .wdata(wdata), .busy(busy),
      .done(done), .rdata(rdata));
   sbs_chk sbs_chk_i (.clk(clk), .rst(rst), .tck(sbs_if_i.tck), .tms(sbs_if_i.tms),
      .tdi(sbs_if_i.tdi), .tdo(sbs_if_i.tdo), .tdo_oe(sbs_if_i.tdo_oe));

   always #20 clk = ~clk;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   // One controller walk, bounded wait for done
   task automatic scan(input logic ir, input logic walk, input int n, input logic [63:0] wd);
      int i;
      repeat (2) @(negedge clk);
      start = 1'b1;
      is_ir = ir;
      go_reset = walk;
      len = 8'(n);
      wdata = wd;
      @(negedge clk);
      start = 1'b0;
      check_val("busy", 64'h1, 64'(busy));
      i = 0;
      while (done !== 1'b1 && i < 2000) begin
         @(negedge clk);
         i++;
      end
      if (done !== 1'b1) begin
         miscompares++;
         summarize();
      end
      check_val("oe idle", 64'h0, 64'(sbs_if_i.tdo_oe));
      check_val("busy idle", 64'h0, 64'(busy));
   endtask : scan

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check_val("instr", 64'(SBS_OP_IDENT), 64'(instr));
      check_val("float", 64'h0, 64'(mem_float));
      check_val("state", 64'(SBS_TLR), 64'(tap_state));
   endtask : t_reset

   task automatic t_ident();
      scan(1'b0, 1'b1, 1, 64'h0);
      check_val("state", 64'(SBS_RTI), 64'(tap_state));
      scan(1'b0, 1'b0, 32, 64'h0);
      check_val("id", 64'(DEV_ID), {32'h0, rdata[31:0]});
   endtask : t_ident

   // Every code but reserved 3 and 5: capture pattern, float, selected path; decode checked for 0, 1, 2 and 4
   task automatic t_codes();
      logic fl;
      for (int c = 0; c < 8; c++) begin
         if (c == 3 || c == 5) continue; // Reserved codes never loaded
         pins = 8'ha5 ^ 8'(c); // Steady pins, no captured bit ignored
         fl = (c == 0 || c == 2);
         scan(1'b1, 1'b0, 3, 64'(c));
         check_val("ir cap", 64'h1, {62'h0, rdata[1:0]});
         if (c < 3 || c == 4) begin
            check_val("instr", 64'(c), 64'(instr));
         end
         check_val("float", 64'(fl), 64'(mem_float));
         if (c == 1) begin
            scan(1'b0, 1'b0, 32, 64'h0);
            check_val("id", 64'(DEV_ID), {32'h0, rdata[31:0]});
         end else if (fl || c == 4) begin
            scan(1'b0, 1'b0, BW, 64'h3c);
            check_val("bsr", 64'(pins), {56'h0, rdata[BW-1:0]});
            check_val("float upd", 64'(fl), 64'(mem_float));
         end else begin
            scan(1'b0, 1'b0, 4, 64'hb);
            check_val("bypass", 64'h6, {60'h0, rdata[3:0]});
         end
      end
   endtask : t_codes

   task automatic t_tlr();
      scan(1'b1, 1'b0, 3, 64'(SBS_OP_CAP_FLOAT));
      scan(1'b0, 1'b1, 1, 64'h0);
      check_val("instr", 64'(SBS_OP_IDENT), 64'(instr));
      check_val("float", 64'h0, 64'(mem_float));
   endtask : t_tlr

   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_ident();
      t_codes();
      t_tlr();
      summarize();
   end
endmodule : sram_boundary_scan_instruction_unit_test
